/* File: hdl/flash_core_port.sv */
// Chosen here: the AXI4-Lite slave port and the register addresses.
`include "flash_guard_cfg.svh"

module flash_core_port (
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic        ce,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic             irq,
    flash_guard_if.core      bus
);

    flash_guard_pkg::host_state_t st_r;
    logic [7:0]  awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0]  wstrb_r;
    logic        aw_have_r;
    logic        w_have_r;
    logic        do_wr;
    logic        ar_hs;
    logic [14:0] addr_r;
    logic [7:0]  cmd_data_r;
    logic [2:0]  cmd_kind_r;
    logic        pend_r;
    logic [7:0]  result_r;
    logic [1:0]  irq_st_r;
    logic [1:0]  irq_en_r;
    logic        busy_q_r;
    logic [1:0]  evt;
    logic [1:0]  clr;

    // Byte-lane merge of a write into a register word.
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] m;
        m = old;
        for (int i = 0; i < 4; i++)
        begin
            if (strb[i])
            begin
                m[8*i +: 8] = nw[8*i +: 8];
            end
        end
        return m;
    endfunction

    assign do_wr = aw_have_r && w_have_r && !s_axi_bvalid;
    assign ar_hs = s_axi_arvalid && s_axi_arready;
    assign clr   = (do_wr && awaddr_r == `REG_IRQ_CLR) ? wdata_r[1:0] : 2'h0;

    ////////////////////////////////////////////////////////////////////////////////
    // Register bus.

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            aw_have_r     <= 1'b0;
            w_have_r      <= 1'b0;
            awaddr_r      <= 8'h00;
            wdata_r       <= 32'h00000000;
            wstrb_r       <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `RESP_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= `RESP_OKAY;
        end
        else if (ce)
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_have_r <= 1'b1;
                awaddr_r  <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_have_r <= 1'b1;
                wdata_r  <= s_axi_wdata;
                wstrb_r  <= s_axi_wstrb;
            end
            s_axi_awready <= !aw_have_r && !(s_axi_awvalid && s_axi_awready);
            s_axi_wready  <= !w_have_r && !(s_axi_wvalid && s_axi_wready);
            if (do_wr)
            begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (awaddr_r <= `REG_IRQ_EN && awaddr_r != `REG_STAT
                                 && awaddr_r[1:0] == 2'h0) ? `RESP_OKAY : `RESP_SLVERR;
            end
            else if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
                aw_have_r    <= 1'b0;
                w_have_r     <= 1'b0;
            end
            s_axi_arready <= !ar_hs && !(s_axi_rvalid && !s_axi_rready);
            if (ar_hs)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= `RESP_OKAY;
                case (s_axi_araddr)
                    `REG_ADDR:   s_axi_rdata <= {17'h00000, addr_r};
                    `REG_CMD:    s_axi_rdata <= {21'h000000, cmd_kind_r, cmd_data_r};
                    `REG_STAT:   s_axi_rdata <= {16'h0000, result_r, 3'h0, bus.ctl_q,
                                                 bus.stall, pend_r, bus.busy};
                    `REG_IRQ_ST: s_axi_rdata <= {30'h00000000, irq_st_r};
                    `REG_IRQ_EN: s_axi_rdata <= {30'h00000000, irq_en_r};
                    default:
                    begin
                        s_axi_rdata <= 32'h00000000;
                        s_axi_rresp <= `RESP_SLVERR;
                    end
                endcase
            end
            else if (s_axi_rvalid && s_axi_rready)
            begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Command launch toward the device.

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            st_r        <= flash_guard_pkg::H_IDLE;
            addr_r      <= 15'h0000;
            cmd_data_r  <= 8'h00;
            cmd_kind_r  <= `CMD_CTL;
            pend_r      <= 1'b0;
            result_r    <= 8'h00;
            bus.sfr_wr  <= 1'b0;
            bus.sfr_sel <= `SEL_CTL;
            bus.data_wr <= 1'b0;
            bus.data_rd <= 1'b0;
            bus.code_rd <= 1'b0;
            bus.addr    <= 15'h0000;
            bus.wdata   <= 8'h00;
        end
        else if (ce)
        begin
            bus.sfr_wr  <= 1'b0;
            bus.data_wr <= 1'b0;
            bus.data_rd <= 1'b0;
            bus.code_rd <= 1'b0;
            if (do_wr && awaddr_r == `REG_ADDR)
            begin
                addr_r <= 15'(merge({17'h00000, addr_r}, wdata_r, wstrb_r));
            end
            if (do_wr && awaddr_r == `REG_CMD && !pend_r)
            begin
                pend_r     <= 1'b1;
                cmd_data_r <= wdata_r[7:0];
                cmd_kind_r <= wdata_r[10:8];
            end
            case (st_r)
                flash_guard_pkg::H_IDLE:
                begin
                    if (pend_r && (!bus.busy || cmd_kind_r == `CMD_CODE))
                    begin
                        bus.addr    <= addr_r;
                        bus.wdata   <= cmd_data_r;
                        bus.sfr_sel <= (cmd_kind_r == `CMD_KEY) ? `SEL_KEY : `SEL_CTL;
                        pend_r      <= 1'b0;
                        case (cmd_kind_r)
                            `CMD_CTL, `CMD_KEY: bus.sfr_wr <= 1'b1;
                            `CMD_WR:
                            begin
                                bus.data_wr <= !evt[`EVT_REFUSED];
                            end
                            `CMD_RD:
                            begin
                                bus.data_rd <= 1'b1;
                                pend_r      <= 1'b1;
                                st_r        <= flash_guard_pkg::H_WAIT_DATA;
                            end
                            `CMD_CODE:
                            begin
                                bus.code_rd <= 1'b1;
                                pend_r      <= 1'b1;
                                st_r        <= flash_guard_pkg::H_WAIT_CODE;
                            end
                            default: pend_r <= 1'b0;
                        endcase
                    end
                end
                flash_guard_pkg::H_WAIT_DATA, flash_guard_pkg::H_WAIT_CODE:
                begin
                    if ((st_r == flash_guard_pkg::H_WAIT_DATA) ? bus.data_done : bus.code_done)
                    begin
                        result_r <= bus.rdata;
                        pend_r   <= 1'b0;
                        st_r     <= flash_guard_pkg::H_IDLE;
                    end
                end
                default: st_r <= flash_guard_pkg::H_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Interrupt status, enable and output.

    always_comb
    begin
        evt               = 2'h0;
        evt[`EVT_DONE]    = busy_q_r && !bus.busy;
        evt[`EVT_REFUSED] = st_r == flash_guard_pkg::H_IDLE && pend_r && !bus.busy
                            && cmd_kind_r == `CMD_WR && bus.ctl_q[0]
                            && addr_r >= `RESERVED_BASE;
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            busy_q_r <= 1'b0;
            irq_st_r <= 2'h0;
            irq_en_r <= 2'h0;
            irq      <= 1'b0;
        end
        else if (ce)
        begin
            busy_q_r <= bus.busy;
            irq_st_r <= (irq_st_r & ~clr) | evt;
            if (do_wr && awaddr_r == `REG_IRQ_EN && wstrb_r[0])
            begin
                irq_en_r <= wdata_r[1:0];
            end
            irq <= |(irq_st_r & irq_en_r) && !bus.irq_hold && !bus.ctl_q[0];
        end
    end

endmodule

/* File: hdl/flash_guard_cfg.svh */
`ifndef FLASH_GUARD_CFG_SVH
`define FLASH_GUARD_CFG_SVH

`define CLK_PERIOD_NS   20
`define WRITE_TIME_NS   40000
`define ERASE_TIME_NS   20000000
`define WRITE_CYC       ((`WRITE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ERASE_CYC       ((`ERASE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`define KEY_FIRST       8'ha5
`define KEY_SECOND      8'hf1
`define ERASED_BYTE     8'hff
`define CTL_WEN_BIT     0
`define CTL_EEN_BIT     1
`define SEL_CTL         1'h0
`define SEL_KEY         1'h1
`define PAGE_BYTES      11'h400
`define RESERVED_BASE   15'h7c00

`define REG_ADDR        8'h00
`define REG_CMD         8'h04
`define REG_STAT        8'h08
`define REG_IRQ_ST      8'h0c
`define REG_IRQ_CLR     8'h10
`define REG_IRQ_EN      8'h14
`define CMD_CTL         3'h0
`define CMD_KEY         3'h1
`define CMD_WR          3'h2
`define CMD_RD          3'h3
`define CMD_CODE        3'h4
`define EVT_DONE        0
`define EVT_REFUSED     1
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

`endif

/* File: hdl/flash_guard_pkg.sv */
package flash_guard_pkg;
    typedef enum logic [1:0] {KEY_IDLE, KEY_HALF, KEY_OPEN, KEY_LOCKED} key_state_t;
    typedef enum logic [1:0] {OP_IDLE, OP_PROG, OP_ERASE} op_state_t;
    typedef enum logic [1:0] {H_IDLE, H_WAIT_DATA, H_WAIT_CODE} host_state_t;
endpackage

/* File: hdl/flash_guard_if.sv */
interface flash_guard_if;
    logic        sfr_wr;
    logic        sfr_sel;
    logic        data_wr;
    logic        data_rd;
    logic        code_rd;
    logic [14:0] addr;
    logic [7:0]  wdata;
    logic [7:0]  rdata;
    logic        data_done;
    logic        code_done;
    logic [1:0]  ctl_q;
    logic        busy;
    logic        stall;
    logic        irq_hold;

    modport dev (
        input  sfr_wr, sfr_sel, data_wr, data_rd, code_rd, addr, wdata,
        output rdata, data_done, code_done, ctl_q, busy, stall, irq_hold
    );
    modport core (
        output sfr_wr, sfr_sel, data_wr, data_rd, code_rd, addr, wdata,
        input  rdata, data_done, code_done, ctl_q, busy, stall, irq_hold
    );
endinterface

/* File: hdl/flash_write_erase_guard.sv */
`include "flash_guard_cfg.svh"

module flash_write_erase_guard #(
    parameter int WRITE_CYCLES = `WRITE_CYC,
    parameter int ERASE_CYCLES = `ERASE_CYC
) (
    input  wire logic   core_clk,
    input  wire logic   rst,
    input  wire logic   ce,
    input  wire logic   vdd_monitor_en,
    output logic        flash_err_reset,
    flash_guard_if.dev  bus
);

    ////////////////////////////////////////////////////////////////////////////////
    // State.

    flash_guard_pkg::key_state_t key_r;
    flash_guard_pkg::op_state_t  op_r;
    logic [19:0]                 cnt_r;
    logic [14:0]                 op_addr_r;
    logic [7:0]                  op_data_r;
    logic                        wen_r;
    logic                        een_r;
    logic                        busy_r;
    logic                        hold_r;
    logic                        stall_r;
    logic                        err_r;
    logic [7:0]                  rdata_r;
    logic                        data_done_r;
    logic                        code_done_r;
    logic                        code_pend_r;
    logic [14:0]                 code_addr_r;
    logic [7:0]                  flash_mem [0:32767];
    logic [7:0]                  external_data_ram_mem [0:1023];
    logic                        flash_try;
    logic                        start;
    logic                        last;
    logic                        op_done;

    // Last count of the running operation.
    function automatic logic [19:0] last_count(input flash_guard_pkg::op_state_t op);
        logic [19:0] n;
        n = 20'(WRITE_CYCLES - 1);
        if (op == flash_guard_pkg::OP_ERASE)
        begin
            n = 20'(ERASE_CYCLES - 1);
        end
        return n;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Decode of a data-space write aimed at flash.

    assign flash_try = bus.data_wr && wen_r && vdd_monitor_en && op_r == flash_guard_pkg::OP_IDLE;
    assign start     = flash_try && key_r == flash_guard_pkg::KEY_OPEN;
    assign last      = cnt_r == last_count(op_r);
    assign op_done   = op_r != flash_guard_pkg::OP_IDLE && last;

    assign flash_err_reset = err_r;
    assign bus.rdata       = rdata_r;
    assign bus.data_done   = data_done_r;
    assign bus.code_done   = code_done_r;
    assign bus.ctl_q       = {een_r, wen_r};
    assign bus.busy        = busy_r;
    assign bus.stall       = stall_r;
    assign bus.irq_hold    = hold_r;

    ////////////////////////////////////////////////////////////////////////////////
    // Key sequence.

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            key_r <= flash_guard_pkg::KEY_IDLE;
        end
        else if (ce)
        begin
            if (key_r == flash_guard_pkg::KEY_LOCKED)
            begin
                key_r <= flash_guard_pkg::KEY_LOCKED;
            end
            else if (op_done)
            begin
                key_r <= flash_guard_pkg::KEY_IDLE;
            end
            else if (bus.sfr_wr && bus.sfr_sel == `SEL_KEY)
            begin
                case (key_r)
                    flash_guard_pkg::KEY_IDLE:
                    begin
                        key_r <= (bus.wdata == `KEY_FIRST) ? flash_guard_pkg::KEY_HALF
                                 : flash_guard_pkg::KEY_LOCKED;
                    end
                    flash_guard_pkg::KEY_HALF:
                    begin
                        key_r <= (bus.wdata == `KEY_SECOND) ? flash_guard_pkg::KEY_OPEN
                                 : flash_guard_pkg::KEY_LOCKED;
                    end
                    default:
                    begin
                        key_r <= flash_guard_pkg::KEY_LOCKED;
                    end
                endcase
            end
            else if (flash_try && key_r != flash_guard_pkg::KEY_OPEN)
            begin
                key_r <= flash_guard_pkg::KEY_LOCKED;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Control bits; they hold until software clears them.

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            wen_r <= 1'b0;
            een_r <= 1'b0;
        end
        else if (ce && bus.sfr_wr && bus.sfr_sel == `SEL_CTL)
        begin
            wen_r <= bus.wdata[`CTL_WEN_BIT];
            een_r <= bus.wdata[`CTL_EEN_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Operation timer.

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            op_r      <= flash_guard_pkg::OP_IDLE;
            cnt_r     <= 20'h00000;
            op_addr_r <= 15'h0000;
            op_data_r <= 8'h00;
            busy_r    <= 1'b0;
            hold_r    <= 1'b0;
        end
        else if (ce)
        begin
            if (start)
            begin
                op_r      <= een_r ? flash_guard_pkg::OP_ERASE
                                   : flash_guard_pkg::OP_PROG;
                cnt_r     <= 20'h00000;
                op_addr_r <= bus.addr;
                op_data_r <= bus.wdata;
                busy_r    <= 1'b1;
                hold_r    <= 1'b1;
            end
            else if (op_done)
            begin
                op_r   <= flash_guard_pkg::OP_IDLE;
                busy_r <= 1'b0;
                hold_r <= 1'b0;
            end
            else if (op_r != flash_guard_pkg::OP_IDLE)
            begin
                cnt_r <= cnt_r + 20'h00001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Flash array.

    always_ff @(posedge core_clk)
    begin
        if (ce && op_r == flash_guard_pkg::OP_PROG && last)
        begin
            flash_mem[op_addr_r] <= flash_mem[op_addr_r] & op_data_r;
        end
        if (ce && op_r == flash_guard_pkg::OP_ERASE && cnt_r < 20'(`PAGE_BYTES))
        begin
            flash_mem[{op_addr_r[14:10], cnt_r[9:0]}] <= `ERASED_BYTE;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // External data RAM.

    always_ff @(posedge core_clk)
    begin
        if (ce && bus.data_wr && !wen_r)
        begin
            external_data_ram_mem[bus.addr[9:0]] <= bus.wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Read answers and code fetch stall.

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            rdata_r     <= 8'h00;
            data_done_r <= 1'b0;
            code_done_r <= 1'b0;
            code_pend_r <= 1'b0;
            code_addr_r <= 15'h0000;
            stall_r     <= 1'b0;
        end
        else if (ce)
        begin
            data_done_r <= bus.data_rd;
            code_done_r <= 1'b0;
            if (bus.data_rd)
            begin
                rdata_r <= external_data_ram_mem[bus.addr[9:0]];
            end
            if (bus.code_rd)
            begin
                code_pend_r <= 1'b1;
                code_addr_r <= bus.addr;
            end
            else if (code_pend_r && !busy_r)
            begin
                rdata_r     <= flash_mem[code_addr_r];
                code_done_r <= 1'b1;
                code_pend_r <= 1'b0;
            end
            stall_r <= (code_pend_r || bus.code_rd) && busy_r && !op_done;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Flash-error reset request.

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            err_r <= 1'b0;
        end
        else if (ce)
        begin
            err_r <= bus.data_wr && wen_r && !vdd_monitor_en;
        end
    end

endmodule

/* File: dv/flash_guard_properties.sv */
module flash_guard_properties #(
    parameter int WRITE_CYCLES = 4,
    parameter int ERASE_CYCLES = 1030
) (
    input wire logic       core_clk,
    input wire logic       rst,
    input wire logic       sfr_wr,
    input wire logic       sfr_sel,
    input wire logic       data_wr,
    input wire logic       data_rd,
    input wire logic       code_rd,
    input wire logic [7:0] wdata,
    input wire logic       data_done,
    input wire logic       code_done,
    input wire logic [1:0] ctl_q,
    input wire logic       busy,
    input wire logic       irq_hold
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    logic [20:0] cnt_r;
    logic        ers_r;
    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            cnt_r <= 21'h000000;
        else
            cnt_r <= busy ? cnt_r + 21'h000001 : 21'h000000;
    end
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            ers_r <= 1'h0;
        else if (data_wr && !busy)
            ers_r <= ctl_q[1];
    end
    ////////////////////////////////////////////////////////////////////////
    a_hold_is_busy: assert property (irq_hold == busy)
        else $error("interrupt hold differs from busy");
    a_busy_cause: assert property ($rose(busy) |-> $past(data_wr))
        else $error("busy rose without a data write");
    a_busy_length: assert property ($fell(busy) |->
        cnt_r == (ers_r ? ERASE_CYCLES : WRITE_CYCLES)) else $error("busy length wrong");
    a_read_answer: assert property (data_rd |=> data_done)
        else $error("data read not answered");
    a_done_cause: assert property (data_done |-> $past(data_rd))
        else $error("data done without read");
    a_code_idle: assert property (code_rd && !busy |-> ##2 code_done)
        else $error("idle code read not answered");
    a_code_free: assert property (code_done |-> !busy)
        else $error("code read answered while busy");
    a_ctl_load: assert property (sfr_wr && !sfr_sel |=> ctl_q == 2'($past(wdata)))
        else $error("control bits not loaded");
    a_ctl_steady: assert property (!$stable(ctl_q) |-> $past(sfr_wr) && !$past(sfr_sel))
        else $error("control bits changed by themselves");
    c_erase: cover property ($fell(busy) && ers_r);
    c_prog: cover property ($fell(busy) && !ers_r);
    c_code_wait: cover property (code_rd && busy);
endmodule

/* File: dv/flash_write_erase_guard_test.sv */
`include "flash_guard_cfg.svh"
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin err_total++; \
 $display("Error at %0t got %h expected %h", $time, (a), (e)); end end
module flash_write_erase_guard_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk = 1'h0, rst = 1'h1, ce = 1'h1, vdd_monitor_en = 1'h1, flash_err_reset, irq;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, st;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
    logic s_axi_rready = 1'h0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid;
    int err_total = 0, comparisons = 0, ferr = 0;
    flash_guard_if fif ();
    flash_write_erase_guard #(.WRITE_CYCLES(4), .ERASE_CYCLES(1030)) i_flash_write_erase_guard (
        .core_clk, .rst, .ce, .vdd_monitor_en, .flash_err_reset, .bus(fif));
    flash_core_port i_flash_core_port (.core_clk, .rst, .ce, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq, .bus(fif));
    flash_guard_properties #(.WRITE_CYCLES(4), .ERASE_CYCLES(1030)) i_flash_guard_properties (
        .core_clk, .rst, .sfr_wr(fif.sfr_wr), .sfr_sel(fif.sfr_sel), .data_wr(fif.data_wr),
        .data_rd(fif.data_rd), .code_rd(fif.code_rd), .wdata(fif.wdata), .data_done(fif.data_done),
        .code_done(fif.code_done), .ctl_q(fif.ctl_q), .busy(fif.busy), .irq_hold(fif.irq_hold));
    ////////////////////////////////////////////////////////////////////////
    initial forever #10 core_clk = ~core_clk;
    always @(posedge core_clk) if (flash_err_reset === 1'h1) ferr++;
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge core_clk);
        s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_awvalid <= 1'h1; s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do begin
            @(posedge core_clk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (s_axi_bvalid !== 1'h1);
        `CHK(s_axi_bresp, er)
        s_axi_bready <= 1'h0;
    endtask
    task automatic axr(input logic [7:0] a);
        @(posedge core_clk);
        s_axi_araddr <= a; s_axi_arvalid <= 1'h1; s_axi_rready <= 1'h1;
        do begin
            @(posedge core_clk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (s_axi_rvalid !== 1'h1);
        st = s_axi_rdata; rsp = s_axi_rresp; s_axi_rready <= 1'h0;
    endtask
    task automatic op(input logic [2:0] k, input logic [7:0] d);
        axw(`REG_CMD, {21'h0, k, d}, `RESP_OKAY);
        repeat (2) do axr(`REG_STAT); while (st[1:0] !== 2'h0);
    endtask
    task automatic key();
        op(`CMD_KEY, `KEY_FIRST); op(`CMD_KEY, `KEY_SECOND);
    endtask
    task automatic fw(input logic [14:0] a, input logic [7:0] c, input logic [7:0] d);
        axw(`REG_ADDR, {17'h0, a}, `RESP_OKAY); op(`CMD_CTL, c);
        op(`CMD_WR, d); op(`CMD_CTL, 8'h00);
    endtask
    task automatic cr(input logic [14:0] a, input logic [7:0] e);
        axw(`REG_ADDR, {17'h0, a}, `RESP_OKAY); op(`CMD_CODE, 8'h00); `CHK(st[15:8], e)
    endtask
    task automatic reset();
        rst <= 1'h1; repeat (16) @(posedge core_clk); rst <= 1'h0;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        #1000000;
        err_total++;
        end_sim();
    end
    initial
    begin
        reset();
        axr(`REG_STAT); `CHK(st, 32'h0)
        axw(8'h18, 32'h1, `RESP_SLVERR); axr(8'h18); `CHK(rsp, `RESP_SLVERR)
        axw(`REG_IRQ_EN, 32'h1, `RESP_OKAY); axw(`REG_ADDR, 32'h10, `RESP_OKAY);
        op(`CMD_WR, 8'h5a); op(`CMD_RD, 8'h00); `CHK(st[15:8], 8'h5a)
        $display("test ram done");
        key(); axw(`REG_ADDR, 32'h5, `RESP_OKAY); op(`CMD_CTL, 8'h03);
        axw(`REG_CMD, {21'h0, `CMD_WR, 8'h00}, `RESP_OKAY);
        axw(`REG_CMD, {21'h0, `CMD_CODE, 8'h00}, `RESP_OKAY); axr(`REG_STAT);
        `CHK(st[2:0], 3'h7)
        do axr(`REG_STAT); while (st[1:0] !== 2'h0);
        `CHK(st[15:0], 16'hff18)
        op(`CMD_CTL, 8'h00); cr(15'h03ff, 8'hff);
        axr(`REG_IRQ_ST); `CHK(st[0], 1'h1) `CHK(irq, 1'h1)
        axw(`REG_IRQ_CLR, 32'h1, `RESP_OKAY); axr(`REG_IRQ_ST); `CHK(irq, 1'h0)
        $display("test erase done");
        key(); fw(15'h0005, 8'h01, 8'ha5); cr(15'h0005, 8'ha5);
        key(); fw(15'h0005, 8'h01, 8'h3c); cr(15'h0005, 8'h24);
        axw(`REG_ADDR, 32'h10, `RESP_OKAY); op(`CMD_CTL, 8'h01); op(`CMD_RD, 8'h00);
        `CHK(st[15:8], 8'h5a)
        `CHK(irq, 1'h0)
        axw(`REG_ADDR, 32'h7c00, `RESP_OKAY); op(`CMD_WR, 8'h00); axr(`REG_IRQ_ST);
        `CHK(st[1], 1'h1)
        op(`CMD_CTL, 8'h00); `CHK(irq, 1'h1)
        fw(15'h0006, 8'h01, 8'h00); key(); fw(15'h0006, 8'h01, 8'h00);
        cr(15'h0006, 8'hff);
        $display("test program done");
        reset(); vdd_monitor_en <= 1'h0; key(); fw(15'h0007, 8'h01, 8'h00);
        `CHK(ferr, 1)
        cr(15'h0007, 8'hff); vdd_monitor_en <= 1'h1;
        reset(); op(`CMD_KEY, `KEY_FIRST); op(`CMD_KEY, 8'h00);
        key(); fw(15'h0007, 8'h01, 8'h00); cr(15'h0007, 8'hff);
        reset(); key(); fw(15'h0008, 8'h01, 8'h0f); cr(15'h0008, 8'h0f);
        fw(15'h0008, 8'h01, 8'h00); cr(15'h0008, 8'h0f);
        $display("test lock done");
        end_sim();
    end
endmodule
